// ===== audio_slot_pkg.sv
package audio_slot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int CH_COUNT = 3;
  localparam int SAMPLE_W = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 12;
  localparam int CFG_W = 7;
  localparam int SLOT_SHIFT = 5;
  localparam int HALF_BIT = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and reset values
  localparam logic [7:0] ADDR_SECOND_CH = 8'h0C;
  localparam logic [7:0] ADDR_THIRD_CH = 8'h0D;
  localparam logic [7:0] ADDR_FOURTH_CH = 8'h0E;
  localparam logic [7:0] RST_SECOND_CH = 8'h01;
  localparam logic [7:0] RST_THIRD_CH = 8'h02;
  localparam logic [7:0] RST_FOURTH_CH = 8'h03;
  localparam logic [7:0] READ_NONE = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Link timing
  localparam logic [CNT_W-1:0] FSYNC_LAT = 12'h002;
  localparam logic [CNT_W-1:0] I2S_DELAY = 12'h001;
  localparam logic [CNT_W-1:0] WORD_BITS = 12'h020;
  localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
  localparam logic [4:0] MSB_IDX = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {FMT_TDM, FMT_I2S, FMT_LJ} format_e;

  // Layout matches the register: line select at bit 6, slot in bits 5..0
  typedef struct packed {
    logic lineSel;
    logic [5:0] slot;
  } chan_cfg_s;

  typedef struct packed {
    chan_cfg_s [CH_COUNT-1:0] chan;
    format_e fmt;
    logic [4:0] offset;
  } frame_cfg_s;

  typedef struct packed {
    logic [CH_COUNT-1:0][SAMPLE_W-1:0] word;
  } sample_set_s;

  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage : audio_slot_pkg

// ===== sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PTR_W:0] DEPTH_CNT = (PTR_W + 1)'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] store_r [DEPTH];
  logic [PTR_W-1:0] wrPtr_r;
  logic [PTR_W-1:0] rdPtr_r;
  logic [PTR_W:0] count_r;
  logic doPush;
  logic doPop;

  // Handshake decode
  assign inReady = (count_r != DEPTH_CNT);
  assign outValid = (count_r != '0);
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;
  assign outData = store_r[rdPtr_r];

  // Storage
  always_ff @(posedge clk)
  begin
    if (doPush)
    begin
      store_r[wrPtr_r] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (doPush)
        wrPtr_r <= (wrPtr_r == LAST_IDX) ? '0 : wrPtr_r + 1'b1;
      if (doPop)
        rdPtr_r <= (rdPtr_r == LAST_IDX) ? '0 : rdPtr_r + 1'b1;
      if (doPush && !doPop)
        count_r <= count_r + 1'b1;
      else if (doPop && !doPush)
        count_r <= count_r - 1'b1;
    end
  end

endmodule : sample_fifo

// ===== audio_slot_channel_mapper.sv
// Operation
// - Line select 0 at bit 6 sends the channel's word to the primary serial output.
// - Line select 1 sends the channel's word to general pin one instead of the primary output.
// - In multi-slot framing the six-bit slot field N in bits 5..0 places the word in slot N.
// - In two-phase framing slot values 0..31 mean left half-frame, slot index equal to the value.
// - In two-phase framing slot values 32..63 mean right half-frame, slot index value minus 32.
// - Second channel register resets to 0x01.
// - Third channel register resets to 0x02.
// - Fourth channel register resets to 0x03.
// - A slot-zero offset of 0..31 bit clocks shifts where the first slot's MSB starts.
`timescale 1ns/1ps
module audio_slot_channel_mapper (
  input wire logic clk,
  input wire logic rst_n,
  input wire audio_slot_pkg::reg_req_s regReq,
  output logic [7:0] regRdData,
  input wire logic sampleValid,
  input wire audio_slot_pkg::sample_set_s sampleIn,
  output logic sampleReady,
  input wire audio_slot_pkg::format_e frameFormat,
  input wire logic [4:0] slotOffset,
  input wire logic bclk,
  input wire logic fsyncIn,
  output logic primarySerialOut,
  output logic primarySerialOutEn,
  output logic generalPinOne,
  output logic generalPinOneEn
);
  import audio_slot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Slot decode: returns {active, bit} for one channel at one bit position
  function automatic logic [1:0] slotBit(
    input chan_cfg_s cfg,
    input logic [SAMPLE_W-1:0] word,
    input format_e fmt,
    input logic [4:0] offset,
    input logic [CNT_W-1:0] pos,
    input logic rightHalf
  );
    logic [5:0] idx;
    logic inHalf;
    logic [CNT_W-1:0] start;
    logic [CNT_W-1:0] rel;
    logic active;
    logic [4:0] bitSel;
    // Multi-slot uses all six bits; two-phase splits half and index
    idx = (fmt == FMT_TDM) ? cfg.slot : {1'b0, cfg.slot[HALF_BIT-1:0]};
    inHalf = (fmt == FMT_TDM) ? 1'b1 : (cfg.slot[HALF_BIT] == rightHalf);
    // Slot start with the slot-zero offset and the one-bit standard stereo delay
    start = CNT_W'(offset) + ((fmt == FMT_I2S) ? I2S_DELAY : '0)
      + (CNT_W'(idx) << SLOT_SHIFT);
    rel = pos - start;
    active = inHalf && (pos >= start) && (rel < WORD_BITS);
    bitSel = MSB_IDX - rel[SLOT_SHIFT-1:0];
    return {active, word[bitSel]};
  endfunction : slotBit

  ////////////////////////////////////////////////////////////////////////////
  // Control domain: channel registers
  chan_cfg_s chanCfg_r [CH_COUNT];
  logic [7:0] regRdData_r;
  logic wrSecond;
  logic wrThird;
  logic wrFourth;
  logic [7:0] rdMux;

  // Address decode
  // Unmapped addresses select nothing
  assign wrSecond = regReq.write && (regReq.addr == ADDR_SECOND_CH);
  assign wrThird = regReq.write && (regReq.addr == ADDR_THIRD_CH);
  assign wrFourth = regReq.write && (regReq.addr == ADDR_FOURTH_CH);

  // Read select, bit 7 forced low, unmapped reads zero
  assign rdMux = (regReq.addr == ADDR_SECOND_CH) ? {1'b0, chanCfg_r[0]} :
    (regReq.addr == ADDR_THIRD_CH) ? {1'b0, chanCfg_r[1]} :
    (regReq.addr == ADDR_FOURTH_CH) ? {1'b0, chanCfg_r[2]} : READ_NONE;
  assign regRdData = regRdData_r;

  // Register writes; only bits 6..0 are stored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chanCfg_r[0] <= RST_SECOND_CH[CFG_W-1:0];
      chanCfg_r[1] <= RST_THIRD_CH[CFG_W-1:0];
      chanCfg_r[2] <= RST_FOURTH_CH[CFG_W-1:0];
    end
    else
    begin
      if (wrSecond)
        chanCfg_r[0] <= regReq.wdata[CFG_W-1:0];
      if (wrThird)
        chanCfg_r[1] <= regReq.wdata[CFG_W-1:0];
      if (wrFourth)
        chanCfg_r[2] <= regReq.wdata[CFG_W-1:0];
    end
  end

  // Registered read data
  // Holds until the next read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdData_r <= READ_NONE;
    else if (regReq.read)
      regRdData_r <= rdMux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control domain: sample buffer
  logic fifoValid;
  sample_set_s fifoData;
  logic fifoPop;

  sample_fifo #(
    .WIDTH($bits(sample_set_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_sample_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .inValid(sampleValid),
    .inData(sampleIn),
    .inReady(sampleReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(fifoPop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control domain: hand-off holding register, toggle request
  sample_set_s holdSet_r;
  frame_cfg_s holdCfg_r;
  frame_cfg_s cfgSnap;
  logic reqTog_r;
  logic ackS1_r;
  logic ackS2_r;
  logic holdBusy;
  logic ackTog_r;

  // Snapshot of configuration sent along with each sample set
  assign cfgSnap.chan = {chanCfg_r[2], chanCfg_r[1], chanCfg_r[0]};
  assign cfgSnap.fmt = frameFormat;
  assign cfgSnap.offset = slotOffset;

  // Holding register stays put while the link has not taken it
  // Link reads the held set only while it is frozen
  assign holdBusy = (reqTog_r != ackS2_r);
  assign fifoPop = fifoValid & ~holdBusy;

  // Acknowledge synchroniser into the control domain
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ackS1_r <= 1'b0;
      ackS2_r <= 1'b0;
    end
    else
    begin
      ackS1_r <= ackTog_r;
      ackS2_r <= ackS1_r;
    end
  end

  // Load a new sample set and flip the request toggle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      holdSet_r <= '0;
      holdCfg_r <= '0;
      reqTog_r <= 1'b0;
    end
    else if (fifoPop)
    begin
      holdSet_r <= fifoData;
      holdCfg_r <= cfgSnap;
      reqTog_r <= ~reqTog_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: synchronisers
  logic fsyncS1_r;
  logic fsyncS2_r;
  logic fsyncPrev_r;
  logic reqS1_r;
  logic reqS2_r;

  // Frame sync and request toggle each pass two flip-flops
  // Only the second stage of each pair feeds logic
  always_ff @(posedge bclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fsyncS1_r <= 1'b0;
      fsyncS2_r <= 1'b0;
      fsyncPrev_r <= 1'b0;
      reqS1_r <= 1'b0;
      reqS2_r <= 1'b0;
    end
    else
    begin
      fsyncS1_r <= fsyncIn;
      fsyncS2_r <= fsyncS1_r;
      fsyncPrev_r <= fsyncS2_r;
      reqS1_r <= reqTog_r;
      reqS2_r <= reqS1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame and half-frame tracking
  sample_set_s frameSet_r;
  frame_cfg_s frameCfg_r;
  logic frameValid_r;
  logic [CNT_W-1:0] posCnt_r;
  logic rightHalf_r;
  logic fsRise;
  logic fsFall;
  logic frameStart;
  logic halfStart;
  logic takeNew;
  logic [CNT_W-1:0] posNxt;
  logic rightNxt;
  sample_set_s setNxt;
  frame_cfg_s cfgNxt;
  logic validNxt;
  logic pending;
  format_e startFmt;

  // Edge events of the synchronised frame sync
  assign fsRise = fsyncS2_r & ~fsyncPrev_r;
  assign fsFall = ~fsyncS2_r & fsyncPrev_r;

  // Waiting set's format picks the edge that opens its frame
  // Old format would open a stereo frame on its right-half edge
  assign pending = (reqS2_r != ackTog_r);
  assign startFmt = pending ? holdCfg_r.fmt : frameCfg_r.fmt;

  // Left half starts on the rise, except standard stereo where it starts on the fall
  assign frameStart = (startFmt == FMT_I2S) ? fsFall : fsRise;
  assign halfStart = (frameCfg_r.fmt == FMT_TDM) ? 1'b0 :
    ((frameCfg_r.fmt == FMT_I2S) ? fsRise : fsFall);
  assign takeNew = frameStart && pending;

  // Bit position counts from the first sampled sync edge, saturating
  // Starting at two makes up for the sync latency
  assign posNxt = (frameStart || halfStart) ? FSYNC_LAT :
    ((posCnt_r == CNT_MAX) ? posCnt_r : posCnt_r + 1'b1);
  assign rightNxt = frameStart ? 1'b0 : (halfStart ? 1'b1 : rightHalf_r);
  assign setNxt = takeNew ? holdSet_r : frameSet_r;
  assign cfgNxt = takeNew ? holdCfg_r : frameCfg_r;
  assign validNxt = frameStart ? takeNew : frameValid_r;

  // Frame state; new set taken only at a frame start
  always_ff @(posedge bclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      posCnt_r <= CNT_MAX;
      rightHalf_r <= 1'b0;
      frameValid_r <= 1'b0;
      frameSet_r <= '0;
      frameCfg_r <= '0;
      ackTog_r <= 1'b0;
    end
    else
    begin
      posCnt_r <= posNxt;
      rightHalf_r <= rightNxt;
      frameValid_r <= validNxt;
      frameSet_r <= setNxt;
      frameCfg_r <= cfgNxt;
      if (takeNew)
        ackTog_r <= ~ackTog_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: per-channel slot decode and line routing
  logic [CH_COUNT-1:0] chActive;
  logic [CH_COUNT-1:0] chBit;
  logic [CH_COUNT-1:0] chOnSecond;

  for (genvar c = 0; c < CH_COUNT; c++)
  begin : g_chan
    logic [1:0] hit;
    assign hit = slotBit(cfgNxt.chan[c], setNxt.word[c], cfgNxt.fmt, cfgNxt.offset,
      posNxt, rightNxt);
    assign chActive[c] = hit[1] & validNxt;
    assign chBit[c] = hit[0];
    assign chOnSecond[c] = cfgNxt.chan[c].lineSel;
  end

  logic primNxt;
  logic primEnNxt;
  logic secNxt;
  logic secEnNxt;

  // Line select steers each active channel to one pin
  // Two channels on one slot and line are ORed
  assign primEnNxt = |(chActive & ~chOnSecond);
  assign primNxt = |(chActive & ~chOnSecond & chBit);
  assign secEnNxt = |(chActive & chOnSecond);
  assign secNxt = |(chActive & chOnSecond & chBit);

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: registered pin drivers
  logic primOut_r;
  logic primEn_r;
  logic secOut_r;
  logic secEn_r;

  // Pins released outside the channel's slot
  // Registering keeps decode ripple off the pins
  always_ff @(posedge bclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primOut_r <= 1'b0;
      primEn_r <= 1'b0;
      secOut_r <= 1'b0;
      secEn_r <= 1'b0;
    end
    else
    begin
      primOut_r <= primNxt;
      primEn_r <= primEnNxt;
      secOut_r <= secNxt;
      secEn_r <= secEnNxt;
    end
  end

  assign primarySerialOut = primOut_r;
  assign primarySerialOutEn = primEn_r;
  assign generalPinOne = secOut_r;
  assign generalPinOneEn = secEn_r;

endmodule : audio_slot_channel_mapper

// ===== slot_mapper_checker.sv
`timescale 1ns/1ps
module slot_mapper_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire audio_slot_pkg::reg_req_s regReq,
  input wire logic [7:0] regRdData,
  input wire logic sampleValid,
  input wire audio_slot_pkg::sample_set_s sampleIn,
  input wire logic sampleReady,
  input wire audio_slot_pkg::format_e frameFormat,
  input wire logic [4:0] slotOffset,
  input wire logic bclk,
  input wire logic fsyncIn,
  input wire logic primarySerialOut,
  input wire logic primarySerialOutEn,
  input wire logic generalPinOne,
  input wire logic generalPinOneEn
);
  import audio_slot_pkg::*;
  logic [2:0][7:0] mirror_r;
  logic [11:0] primRun_r, genRun_r, bitPos_r;
  logic fsyncPrev_r;
  // Decoded helpers
  wire [7:0] regIdx = regReq.addr - ADDR_SECOND_CH;
  wire twoPhase = frameFormat != FMT_TDM;
  wire [11:0] lag = bitPos_r - {7'h00, slotOffset} - {11'h000, frameFormat == FMT_I2S};
  wire frameStart = twoPhase ? fsyncIn != fsyncPrev_r : fsyncIn && !fsyncPrev_r;

  // Register mirror
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      mirror_r <= {8'h03, 8'h02, 8'h01};
    else if (regReq.write && regIdx < 8'h03)
      mirror_r[regIdx[1:0]] <= {1'b0, regReq.wdata[6:0]};

  // Enable run lengths and bit position in the frame (multi-slot) or half-frame (two-phase)
  always_ff @(posedge bclk or negedge rst_n)
    if (!rst_n)
    begin
      primRun_r <= 12'h000;
      genRun_r <= 12'h000;
      bitPos_r <= 12'h000;
      fsyncPrev_r <= 1'b0;
    end
    else
    begin
      primRun_r <= primarySerialOutEn ? primRun_r + 12'h001 : 12'h000;
      genRun_r <= generalPinOneEn ? genRun_r + 12'h001 : 12'h000;
      bitPos_r <= frameStart ? 12'h000 : bitPos_r + 12'h001;
      fsyncPrev_r <= fsyncIn;
    end

  ////////////////////////////////////////////////////////////
  chk_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.read |=> regRdData[7] == 1'b0) else $error("reserved bit reads one");
  chk_second_read: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.read && regReq.addr == ADDR_SECOND_CH |=> regRdData == $past(mirror_r[0]))
    else $error("second channel readback wrong");
  chk_third_read: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.read && regReq.addr == ADDR_THIRD_CH |=> regRdData == $past(mirror_r[1]))
    else $error("third channel readback wrong");
  chk_fourth_read: assert property (@(posedge clk) disable iff (!rst_n)
    regReq.read && regReq.addr == ADDR_FOURTH_CH |=> regRdData == $past(mirror_r[2]))
    else $error("fourth channel readback wrong");
  chk_primary_word: assert property (@(posedge bclk) disable iff (!rst_n)
    $fell(primarySerialOutEn) |-> primRun_r[4:0] == 5'h00 && primRun_r != 12'h000)
    else $error("primary word not whole");
  chk_general_word: assert property (@(posedge bclk) disable iff (!rst_n)
    $fell(generalPinOneEn) |-> genRun_r[4:0] == 5'h00 && genRun_r != 12'h000)
    else $error("secondary word not whole");
  chk_tdm_slot: assert property (@(posedge bclk) disable iff (!rst_n)
    !twoPhase && ($rose(primarySerialOutEn) || $rose(generalPinOneEn)) |-> lag[4:0] == 5'h00)
    else $error("slot start misplaced");
  chk_half_slot: assert property (@(posedge bclk) disable iff (!rst_n)
    twoPhase && ($rose(primarySerialOutEn) || $rose(generalPinOneEn)) |-> lag[4:0] == 5'h00)
    else $error("half-frame slot misplaced");
  cover property (@(posedge clk) disable iff (!rst_n) !sampleReady);
  cover property (@(posedge bclk) disable iff (!rst_n) $rose(generalPinOneEn));
  cover property (@(posedge bclk) disable iff (!rst_n) twoPhase && $rose(primarySerialOutEn));
endmodule : slot_mapper_checker

bind audio_slot_channel_mapper slot_mapper_checker checker_u (.clk(clk), .rst_n(rst_n),
  .regReq(regReq), .regRdData(regRdData), .sampleValid(sampleValid), .sampleIn(sampleIn),
  .sampleReady(sampleReady), .frameFormat(frameFormat), .slotOffset(slotOffset),
  .bclk(bclk), .fsyncIn(fsyncIn), .primarySerialOut(primarySerialOut),
  .primarySerialOutEn(primarySerialOutEn), .generalPinOne(generalPinOne),
  .generalPinOneEn(generalPinOneEn));

// ===== serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model #(
  parameter int FRAME = 512,
  parameter int PRE = 8
) (
  input wire logic go,
  input wire audio_slot_pkg::format_e fmt,
  input wire logic primarySerialOut,
  input wire logic primarySerialOutEn,
  input wire logic generalPinOne,
  input wire logic generalPinOneEn,
  output logic bclk,
  output logic fsyncIn,
  output logic done,
  output logic [FRAME-1:0] primBits,
  output logic [FRAME-1:0] primEn,
  output logic [FRAME-1:0] genBits,
  output logic [FRAME-1:0] genEn
);
  import audio_slot_pkg::*;
  logic idle;
  int pos;

  // Clock parked low between frames
  initial
  begin
    bclk = 1'b0;
    fsyncIn = 1'b0;
    done = 1'b1;
  end

  // One frame per request, short idle lead-in for the crossing
  always @(posedge go)
  begin
    done = 1'b0;
    idle = fmt == FMT_I2S;
    fsyncIn = idle;
    primEn = '0;
    genEn = '0;
    #3;
    for (int n = 0; n <= PRE + FRAME; n++)
    begin
      pos = n - PRE - 1;
      // Sample what the previous rising edge launched
      if (pos >= 0)
      begin
        primBits[pos] = primarySerialOut;
        primEn[pos] = primarySerialOutEn;
        genBits[pos] = generalPinOne;
        genEn[pos] = generalPinOneEn;
      end
      bclk = 1'b1;
      #32;
      bclk = 1'b0;
      pos = n + 1 - PRE;
      fsyncIn = (pos >= 0 && pos < FRAME) ? (pos < FRAME / 2) ^ idle : idle;
      #32;
    end
    done = 1'b1;
  end
endmodule : serial_host_model

// ===== testbench.sv
`timescale 1ns/1ps
module testbench;
  import audio_slot_pkg::*;
  logic clk, rst_n, sampleValid, sampleReady, bclk, fsyncIn, go, done;
  logic primarySerialOut, primarySerialOutEn, generalPinOne, generalPinOneEn;
  reg_req_s regReq;
  logic [7:0] regRdData;
  sample_set_s sampleIn;
  format_e frameFormat;
  logic [4:0] slotOffset;
  logic [511:0] primBits, primEn, genBits, genEn;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  audio_slot_channel_mapper DUT (.clk(clk), .rst_n(rst_n), .regReq(regReq),
    .regRdData(regRdData), .sampleValid(sampleValid), .sampleIn(sampleIn),
    .sampleReady(sampleReady), .frameFormat(frameFormat), .slotOffset(slotOffset),
    .bclk(bclk), .fsyncIn(fsyncIn), .primarySerialOut(primarySerialOut),
    .primarySerialOutEn(primarySerialOutEn), .generalPinOne(generalPinOne),
    .generalPinOneEn(generalPinOneEn));
  serial_host_model #(.FRAME(512), .PRE(8)) host (.go(go), .fmt(frameFormat),
    .primarySerialOut(primarySerialOut), .primarySerialOutEn(primarySerialOutEn),
    .generalPinOne(generalPinOne), .generalPinOneEn(generalPinOneEn), .bclk(bclk),
    .fsyncIn(fsyncIn), .done(done), .primBits(primBits), .primEn(primEn),
    .genBits(genBits), .genEn(genEn));

  // Control clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    regReq = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
    @(negedge clk);
    regReq.write = 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    regReq = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge clk);
    regReq.read = 1'b0;
    data = regRdData;
  endtask : reg_read

  task automatic set_cfg(input logic [7:0] c2, c3, c4, input format_e f, input logic [4:0] o);
    reg_write(ADDR_SECOND_CH, c2);
    reg_write(ADDR_THIRD_CH, c3);
    reg_write(ADDR_FOURTH_CH, c4);
    frameFormat = f;
    slotOffset = o;
  endtask : set_cfg

  task automatic push(input logic [31:0] base);
    @(negedge clk);
    sampleIn = {base + 32'h0200_0000, base + 32'h0100_0000, base};
    sampleValid = 1'b1;
    for (int n = 0; n < 100 && sampleReady !== 1'b1; n++)
      @(negedge clk);
    check("set taken", sampleReady, 1'b1);
    @(negedge clk);
    sampleValid = 1'b0;
  endtask : push

  task automatic run_frame;
    @(negedge clk);
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (int n = 0; n < 5000 && done !== 1'b1; n++)
      @(negedge clk);
    check("frame done", done, 1'b1);
  endtask : run_frame

  task automatic check_chan(input string what, input logic [31:0] word, input chan_cfg_s cfg);
    int start;
    logic [31:0] bits, en, other;
    start = slotOffset + (frameFormat == FMT_I2S) + 32 * cfg.slot;
    if (frameFormat != FMT_TDM)
      start = slotOffset + (frameFormat == FMT_I2S) + 256 * cfg.slot[5] + 32 * cfg.slot[4:0];
    for (int b = 0; b < 32; b++)
    begin
      bits[31 - b] = cfg.lineSel ? genBits[start + b] : primBits[start + b];
      en[b] = cfg.lineSel ? genEn[start + b] : primEn[start + b];
      other[b] = cfg.lineSel ? primEn[start + b] : genEn[start + b];
    end
    check({what, " data"}, bits, word);
    check({what, " enable"}, en, 32'hFFFF_FFFF);
    check({what, " other line"}, other, 32'h0000_0000);
  endtask : check_chan

  ////////////////////////////////////////////////////////////
  task automatic test_reset_values;
    logic [7:0] v;
    reg_read(ADDR_SECOND_CH, v);
    check("second reset", v, 8'h01);
    reg_read(ADDR_THIRD_CH, v);
    check("third reset", v, 8'h02);
    reg_read(ADDR_FOURTH_CH, v);
    check("fourth reset", v, 8'h03);
    $display("test_reset_values done");
  endtask : test_reset_values

  task automatic test_reserved_bit;
    logic [7:0] v;
    for (int a = 0; a < 3; a++)
    begin
      reg_write(ADDR_SECOND_CH + 8'(a), 8'hFF);
      reg_read(ADDR_SECOND_CH + 8'(a), v);
      check("all ones written", v, 8'h7F);
    end
    reg_write(8'h0F, 8'h55);
    reg_read(8'h0F, v);
    check("unmapped", v, 8'h00);
    $display("test_reserved_bit done");
  endtask : test_reserved_bit

  task automatic test_tdm_fill;
    set_cfg(8'h0E, 8'h40, 8'h42, FMT_TDM, 5'h02);
    for (int i = 0; i < 5; i++)
      push(32'h0035_A7C0 + i);
    @(negedge clk);
    check("ready when full", sampleReady, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      run_frame();
      check_chan("tdm ch2", 32'h0035_A7C0 + i, 7'h0E);
      check_chan("tdm ch3", 32'h0135_A7C0 + i, 7'h40);
      check_chan("tdm ch4", 32'h0235_A7C0 + i, 7'h42);
    end
    check("ready when empty", sampleReady, 1'b1);
    $display("test_tdm_fill done");
  endtask : test_tdm_fill

  task automatic test_two_phase;
    for (int k = 0; k < 2; k++)
    begin
      set_cfg(8'h01, 8'h20, 8'h66, k ? FMT_I2S : FMT_LJ, 5'h03);
      push(32'h00C6_1B40 + k);
      run_frame();
      check_chan("left ch2", 32'h00C6_1B40 + k, 7'h01);
      check_chan("right ch3", 32'h01C6_1B40 + k, 7'h20);
      check_chan("right ch4", 32'h02C6_1B40 + k, 7'h66);
    end
    $display("test_two_phase done");
  endtask : test_two_phase

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    regReq = '0;
    sampleValid = 1'b0;
    sampleIn = '0;
    frameFormat = FMT_TDM;
    slotOffset = 5'h00;
    go = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    test_reset_values();
    test_reserved_bit();
    test_tdm_fill();
    test_two_phase();
    end_of_test();
  end
endmodule : testbench
